// ===== core/afsb_defs.svh
// Constants for the almost-full status bus control block
`ifndef AFSB_DEFS_SVH
`define AFSB_DEFS_SVH

// Register offsets, byte addresses on the plain register port
`define AFSB_OFS_CTRL 8'h00
`define AFSB_OFS_MODE 8'h04
`define AFSB_OFS_STATUS 8'h08
`define AFSB_OFS_MASK 8'h0C

// Control register fields
`define AFSB_CTRL_PROG_DONE 0
`define AFSB_CTRL_CHAIN_HEAD 1
`define AFSB_CTRL_W 2
`define AFSB_CTRL_RST 2'h0

// Mode register fields, read only
`define AFSB_MODE_POLLED 0
`define AFSB_MODE_STD 1
`define AFSB_MODE_RUN 2
`define AFSB_MODE_IDX_LSB 3
`define AFSB_MODE_IDX_MSB 4

// Event bits, shared by status and mask
`define AFSB_EV_SELECT 0
`define AFSB_EV_WRAP 1
`define AFSB_EV_STRB_ERR 2
`define AFSB_EV_W 3
`define AFSB_EV_RST 3'h0

// Status word layout
`define AFSB_FLAG_W 8
`define AFSB_WORDS 4
`define AFSB_FLAGS_W 32
`define AFSB_ADDR_W 8
`define AFSB_WORD_LSB 3
`define AFSB_WORD_MSB 4
`define AFSB_FIRST_WORD 2'h0
`define AFSB_LAST_WORD 2'h3

// Register port widths
`define AFSB_REG_AW 8
`define AFSB_REG_DW 32

`endif

// ===== core/afsb_pkg.sv
// Types shared by the almost-full status bus control block
package afsb_pkg;

    // Pin inputs that travel together through the synchroniser
    typedef struct packed {
        logic strobe;
        logic exp_in;
        logic flag_mode;
        logic fall_thru;
        logic [7:0] addr;
    } afsb_pins_t;

    // Modes caught while the master reset is held
    typedef struct packed {
        logic polled;
        logic std_read;
    } afsb_cfg_t;

    // Polling sequencer states
    typedef enum logic {
        AFSB_POLL_IDLE,
        AFSB_POLL_RUN
    } afsb_poll_st_t;

endpackage

// ===== core/afsb_sync.sv
// Two flip-flop synchroniser for a vector of slow pin levels
`timescale 1ns/1ps
module afsb_sync #(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // First stage, read only by the second stage
    logic [W-1:0] meta;

    // Both stages run free so levels pass even during reset
    always_ff @(posedge clk) begin
        meta <= d;
        q <= meta;
    end

endmodule

// ===== core/afsb_ctrl.sv
// Almost-full status flag bus control, write clock side
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "afsb_defs.svh"
module afsb_ctrl
    import afsb_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic flag_mode_select,
    input wire logic fall_through_select,
    input wire logic almost_full_bus_strobe,
    input wire logic almost_full_expansion_in,
    input wire logic [`AFSB_ADDR_W-1:0] write_queue_address_bus,
    input wire logic [`AFSB_FLAGS_W-1:0] queue_almost_full,
    input wire logic [`AFSB_REG_AW-1:0] reg_addr,
    input wire logic [`AFSB_REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`AFSB_REG_DW-1:0] reg_rdata,
    output logic [`AFSB_FLAG_W-1:0] almost_full_flag_bus,
    output logic almost_full_bus_sync,
    output logic almost_full_expansion_out,
    output logic serial_enable_out,
    output logic standard_read_mode,
    output logic irq
);

    // Picks one status word out of the flat flag vector
    function automatic logic [`AFSB_FLAG_W-1:0] word_of(
        input logic [`AFSB_FLAGS_W-1:0] flags,
        input logic [1:0] idx
    );
        word_of = flags[idx*`AFSB_FLAG_W +: `AFSB_FLAG_W];
    endfunction

    // Raw pins grouped, then synchronised
    afsb_pins_t pins_raw;
    afsb_pins_t pins_s;
    // Previous synchronised token level, for the edge
    logic exp_in_d;
    // Token rising edge seen this cycle
    logic tok_rise;
    // Modes caught during reset
    afsb_cfg_t cfg;
    // Software control bits
    logic [`AFSB_CTRL_W-1:0] ctrl;
    // Sticky events, interrupt mask, events this cycle
    logic [`AFSB_EV_W-1:0] status;
    logic [`AFSB_EV_W-1:0] mask;
    logic [`AFSB_EV_W-1:0] ev;
    // Polling sequencer state and next word to show
    afsb_poll_st_t poll_st;
    logic [1:0] word_idx;
    // Chain head has already launched its first round
    logic head_started;
    // Decoded strobes
    logic prog_done;
    logic chain_head;
    logic direct_sel;
    logic poll_go;
    logic strobe_err;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;

    // Gather the pins that cross into the write clock domain
    assign pins_raw.strobe = almost_full_bus_strobe;
    assign pins_raw.exp_in = almost_full_expansion_in;
    assign pins_raw.flag_mode = flag_mode_select;
    assign pins_raw.fall_thru = fall_through_select;
    assign pins_raw.addr = write_queue_address_bus;

    // Every pin passes two flops before any logic sees it
    afsb_sync #(
        .W($bits(afsb_pins_t))
    ) u_sync (
        .clk(clk),
        .d(pins_raw),
        .q(pins_s)
    );

    // Control bits in plain form
    assign prog_done = ctrl[`AFSB_CTRL_PROG_DONE];
    assign chain_head = ctrl[`AFSB_CTRL_CHAIN_HEAD];

    // Serial enable drops once programming is done
    assign serial_enable_out = ~prog_done;

    // Read mode pin level straight from the latched mode
    assign standard_read_mode = cfg.std_read;

    // Token edge, taken from the second stage only
    assign tok_rise = pins_s.exp_in & ~exp_in_d;

    // Direct select needs direct mode and finished programming
    assign direct_sel = ~cfg.polled & pins_s.strobe & prog_done;

    // Strobe seen in polled mode or before programming ends
    assign strobe_err = pins_s.strobe &
        (cfg.polled | ~prog_done);

    // Start a round on a token, or once as the chain head
    assign poll_go = cfg.polled & prog_done &
        (tok_rise | (chain_head & ~head_started));

    // Register write decode
    assign wr_ctrl = reg_wr & (reg_addr == `AFSB_OFS_CTRL);
    assign wr_status = reg_wr & (reg_addr == `AFSB_OFS_STATUS);
    assign wr_mask = reg_wr & (reg_addr == `AFSB_OFS_MASK);

    // Token edge memory
    always_ff @(posedge clk) begin
        if (!rstn) begin
            exp_in_d <= 1'b0;
        end else begin
            exp_in_d <= pins_s.exp_in;
        end
    end

    // Mode pins are followed while reset is held, then frozen
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cfg.polled <= pins_s.flag_mode;
            cfg.std_read <= pins_s.fall_thru;
        end
    end

    // Control register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl <= `AFSB_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl <= reg_wdata[`AFSB_CTRL_W-1:0];
        end
    end

    // Chain head launches one round, the loop carries the rest
    always_ff @(posedge clk) begin
        if (!rstn) begin
            head_started <= 1'b0;
        end else if (poll_go) begin
            head_started <= 1'b1;
        end
    end

    // Polling sequencer walks words one to four
    always_ff @(posedge clk) begin
        if (!rstn) begin
            poll_st <= AFSB_POLL_IDLE;
            word_idx <= `AFSB_FIRST_WORD;
        end else begin
            case (poll_st)
                // Waiting for the token
                AFSB_POLL_IDLE: begin
                    if (poll_go) begin
                        poll_st <= AFSB_POLL_RUN;
                        word_idx <= word_idx + 2'h1;
                    end
                end
                // Showing words two to four
                AFSB_POLL_RUN: begin
                    word_idx <= word_idx + 2'h1;
                    if (word_idx == `AFSB_LAST_WORD) begin
                        poll_st <= AFSB_POLL_IDLE;
                    end
                end
                default: begin
                    poll_st <= AFSB_POLL_IDLE;
                    word_idx <= `AFSB_FIRST_WORD;
                end
            endcase
        end
    end

    // Flag bus, sync and token output
    always_ff @(posedge clk) begin
        if (!rstn) begin
            almost_full_flag_bus <= '0;
            almost_full_bus_sync <= 1'b0;
            almost_full_expansion_out <= 1'b0;
        end else if (poll_st == AFSB_POLL_RUN) begin
            // Next word of the round
            almost_full_flag_bus <= word_of(queue_almost_full,
                word_idx);
            almost_full_bus_sync <= 1'b0;
            almost_full_expansion_out <=
                (word_idx == `AFSB_LAST_WORD);
        end else if (poll_go) begin
            // Word one opens the round
            almost_full_flag_bus <= word_of(queue_almost_full,
                `AFSB_FIRST_WORD);
            almost_full_bus_sync <= 1'b1;
            almost_full_expansion_out <= 1'b0;
        end else if (direct_sel) begin
            // Addressed word replaces the held one
            almost_full_flag_bus <= word_of(queue_almost_full,
                pins_s.addr[`AFSB_WORD_MSB:`AFSB_WORD_LSB]);
            almost_full_bus_sync <= 1'b0;
            almost_full_expansion_out <= 1'b0;
        end else begin
            // Bus holds its word between strobes
            almost_full_bus_sync <= 1'b0;
            almost_full_expansion_out <= 1'b0;
        end
    end

    // Events of this cycle
    always_comb begin
        ev = '0;
        ev[`AFSB_EV_SELECT] = direct_sel;
        ev[`AFSB_EV_WRAP] = (poll_st == AFSB_POLL_RUN) &
            (word_idx == `AFSB_LAST_WORD);
        ev[`AFSB_EV_STRB_ERR] = strobe_err;
    end

    // Sticky status, write one clears, a new event wins
    always_ff @(posedge clk) begin
        if (!rstn) begin
            status <= `AFSB_EV_RST;
        end else if (wr_status) begin
            status <= (status & ~reg_wdata[`AFSB_EV_W-1:0]) | ev;
        end else begin
            status <= status | ev;
        end
    end

    // Interrupt mask
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mask <= `AFSB_EV_RST;
        end else if (wr_mask) begin
            mask <= reg_wdata[`AFSB_EV_W-1:0];
        end
    end

    // Level interrupt while any unmasked event is pending
    assign irq = |(status & mask);

    // Read data, valid in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            case (reg_addr)
                `AFSB_OFS_CTRL: begin
                    reg_rdata[`AFSB_CTRL_W-1:0] <= ctrl;
                end
                `AFSB_OFS_MODE: begin
                    reg_rdata[`AFSB_MODE_POLLED] <= cfg.polled;
                    reg_rdata[`AFSB_MODE_STD] <= cfg.std_read;
                    reg_rdata[`AFSB_MODE_RUN] <=
                        (poll_st == AFSB_POLL_RUN);
                    reg_rdata[`AFSB_MODE_IDX_MSB:`AFSB_MODE_IDX_LSB]
                        <= word_idx;
                end
                `AFSB_OFS_STATUS: begin
                    reg_rdata[`AFSB_EV_W-1:0] <= status;
                end
                `AFSB_OFS_MASK: begin
                    reg_rdata[`AFSB_EV_W-1:0] <= mask;
                end
                // Unmapped addresses read as zero
                default: begin
                    reg_rdata <= '0;
                end
            endcase
        end
    end

endmodule

// ===== tb/afsb_chk.sv
// Property checker for the almost-full status bus control
`timescale 1ns/1ps
`include "afsb_defs.svh"
module afsb_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic flag_mode_select,
    input wire logic almost_full_bus_strobe,
    input wire logic [`AFSB_ADDR_W-1:0] write_queue_address_bus,
    input wire logic [`AFSB_FLAGS_W-1:0] queue_almost_full,
    input wire logic [`AFSB_FLAG_W-1:0] almost_full_flag_bus,
    input wire logic almost_full_bus_sync,
    input wire logic almost_full_expansion_out,
    input wire logic serial_enable_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Recent strobe levels, deep enough to cover the pin synchroniser
    logic [5:0] strb_hist;
    // Word that the present address picks
    logic [7:0] sel_word;
    always_ff @(posedge clk) begin
        strb_hist <= {strb_hist[4:0], almost_full_bus_strobe};
    end
    assign sel_word = queue_almost_full[8*write_queue_address_bus[
        `AFSB_WORD_MSB:`AFSB_WORD_LSB] +: 8];

    rst_state_a: assert property ($rose(rstn) |->
        serial_enable_out && almost_full_flag_bus == 8'h00 &&
        !almost_full_bus_sync) else $error("outputs wrong at reset release");
    direct_nosync_a: assert property (!flag_mode_select
        |-> !almost_full_bus_sync) else $error("sync in direct mode");
    sync_word_a: assert property (almost_full_bus_sync |->
        almost_full_flag_bus == $past(queue_almost_full[7:0]))
        else $error("sync without word one");
    sync_once_a: assert property (almost_full_bus_sync
        |=> !almost_full_bus_sync) else $error("sync longer than a cycle");
    poll_order_a: assert property (almost_full_bus_sync |=>
        almost_full_flag_bus == $past(queue_almost_full[15:8]) ##1
        almost_full_flag_bus == $past(queue_almost_full[23:16]))
        else $error("polled words out of order");
    token_out_a: assert property (almost_full_bus_sync |-> ##3
        almost_full_expansion_out &&
        almost_full_flag_bus == $past(queue_almost_full[31:24]))
        else $error("token not with word four");
    token_pulse_a: assert property (almost_full_expansion_out
        |=> !almost_full_expansion_out) else $error("token too long");
    direct_sel_a: assert property (!flag_mode_select &&
        almost_full_bus_strobe && !serial_enable_out |->
        ##[2:5] almost_full_flag_bus == sel_word)
        else $error("strobed word not selected");
    direct_hold_a: assert property (!flag_mode_select &&
        $changed(almost_full_flag_bus) |-> |strb_hist)
        else $error("bus changed without strobe");
endmodule
bind afsb_ctrl afsb_chk afsb_chk_inst (.clk, .rstn, .flag_mode_select,
    .almost_full_bus_strobe, .write_queue_address_bus, .queue_almost_full,
    .almost_full_flag_bus, .almost_full_bus_sync,
    .almost_full_expansion_out, .serial_enable_out);

// ===== tb/afsb_far.sv
// External flow controller and expansion wiring model
`timescale 1ns/1ps
module afsb_far (
    input wire logic clk,
    input wire logic polled,
    input wire logic std_rd,
    input wire logic exp_out,
    output logic flag_mode,
    output logic fall_thru,
    output logic strobe,
    output logic [7:0] addr,
    output logic exp_in
);
    // Mode pins move only while the bench holds reset
    assign flag_mode = polled;
    assign fall_thru = std_rd;
    // Token looped back when polled, tied low when direct
    assign exp_in = polled ?
        exp_out : 1'b0;
    initial begin
        strobe = 1'b0;
        addr = 8'h00;
    end
    // One-cycle strobe for word k, address held while it is taken
    task automatic pick(input logic [1:0] k);
        @(posedge clk);
        strobe <= 1'b1;
        addr <= {3'h0, k, 3'h0};
        @(posedge clk);
        strobe <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
    endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the almost-full status bus control
`timescale 1ns/1ps
`include "afsb_defs.svh"
module tb;
    logic clk, rstn, polled, std_rd, reg_wr, reg_rd;
    logic [7:0] reg_addr, bus, addr;
    logic [31:0] reg_wdata, qaf, reg_rdata;
    logic sync, exp_out, exp_in, seo, std_mode, irq, fm, ft, strobe;
    int err_count = 0;
    int n_checks = 0;

    afsb_ctrl afsb_ctrl_inst (.clk(clk), .rstn(rstn),
        .flag_mode_select(fm), .fall_through_select(ft),
        .almost_full_bus_strobe(strobe), .almost_full_expansion_in(exp_in),
        .write_queue_address_bus(addr), .queue_almost_full(qaf),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .almost_full_flag_bus(bus),
        .almost_full_bus_sync(sync), .almost_full_expansion_out(exp_out),
        .serial_enable_out(seo), .standard_read_mode(std_mode), .irq(irq));
    afsb_far afsb_far_inst (.clk(clk), .polled(polled), .std_rd(std_rd),
        .exp_out(exp_out), .flag_mode(fm), .fall_thru(ft), .strobe(strobe),
        .addr(addr), .exp_in(exp_in));

    // Free-running 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %0h expected %0h",
                $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands from the cycle after the strobe until the next read strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
    endtask
    // Pins settle long before release; 12 cycles of reset
    task automatic do_reset(input logic p, input logic s);
        rstn <= 1'b0;
        polled <= p;
        std_rd <= s;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        tick;
    endtask
    task automatic wait_sync;
        for (int i = 0; i < 40; i++) begin
            tick;
            if (sync === 1'b1) return;
        end
        err_count++;
        close_out;
    endtask

    // Direct mode: early strobe refused, then every word picked
    task automatic t_direct;
        qaf <= 32'hF00F_A55A;
        do_reset(1'b0, 1'b1);
        check(seo, 1'b1);
        check(std_mode, 1'b1);
        rd(`AFSB_OFS_MODE);
        check(reg_rdata[1:0], 2'b10);
        rd(`AFSB_OFS_CTRL);
        check(reg_rdata, 32'h0);
        rd(8'h10);
        check(reg_rdata, 32'h0);
        afsb_far_inst.pick(2'h2);
        check(bus, 8'h00);
        rd(`AFSB_OFS_STATUS);
        check(reg_rdata[2], 1'b1);
        wr(`AFSB_OFS_STATUS, 32'h4);
        wr(`AFSB_OFS_MASK, 32'h1);
        wr(`AFSB_OFS_CTRL, 32'h1);
        tick;
        check(seo, 1'b0);
        check(irq, 1'b0);
        for (int k = 3; k >= 0; k--) begin
            afsb_far_inst.pick(k[1:0]);
            check(bus, qaf[8*k +: 8]);
        end
        repeat (8) tick;
        check(bus, qaf[7:0]);
        check(irq, 1'b1);
        wr(`AFSB_OFS_MASK, 32'h0);
        tick;
        check(irq, 1'b0);
        wr(`AFSB_OFS_STATUS, 32'h1);
        wr(`AFSB_OFS_MASK, 32'h1);
        tick;
        check(irq, 1'b0);
        rd(`AFSB_OFS_MASK);
        check(reg_rdata, 32'h1);
    endtask

    // Polled mode on a looped single device, two rounds
    task automatic t_polled;
        @(posedge clk);
        qaf <= 32'h3C96_C3A5;
        do_reset(1'b1, 1'b0);
        check(std_mode, 1'b0);
        rd(`AFSB_OFS_MODE);
        check(reg_rdata[1:0], 2'b01);
        wr(`AFSB_OFS_MASK, 32'h2);
        wr(`AFSB_OFS_CTRL, 32'h3);
        for (int r = 0; r < 2; r++) begin
            wait_sync;
            for (int k = 0; k < 4; k++) begin
                check(bus, qaf[8*k +: 8]);
                check(sync, k == 0);
                check(exp_out, k == 3);
                tick;
            end
            check(exp_out, 1'b0);
        end
        check(irq, 1'b1);
        rd(`AFSB_OFS_STATUS);
        check(reg_rdata[1], 1'b1);
    endtask

    initial begin
        rstn = 1'b0;
        polled = 1'b0;
        std_rd = 1'b0;
        qaf = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        t_direct;
        t_polled;
        close_out;
    end
    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        close_out;
    end
endmodule
